// ===== core/sbcsm_bank_fsm.sv
`timescale 1ns/10ps
// Contract
// R01: Command legality applies only after clock enable high
// R02: Read autoclose burst ends, then precharging
// R03: Write autoclose burst ends, recovery, then precharge
// R04: Controller avoids commands to busy autoclose banks
// R05: Illegal command may suit another addressed bank
// R06: Precharging ignores nops, idle after precharge period
// R07: Write recovery nops, then row active
// R08: Write recovery accepts read or write
// R09: Autoclose recovery nops, then precharge; others illegal; code also accepts burst stop in autoclose recovery
// R10: Refreshing allows only nops, idle after row cycle; code also accepts burst stop while refreshing
// R11: Controller meets burst interrupt timing
// R12: Controller masks early write data on precharge
// R13: All idle, enable low, refresh: self refresh
// R14: Idle or active, enable low: power down
// R15: Self refresh only from all banks idle
// R16: Power down held while low, exit on rise
// R17: Self refresh exits on rise with nop only
// R18: Self refresh recovery nops, idle after row cycle
// R19: Other states: enable edges start or end suspend
// R20: Suspend entry command must be legal
// R21: Mode access allows only deselect or nop
// R22: Controller counts intervals per bank, rounding up
module sbcsm_bank_fsm
   import sbcsm_pkg::*;
#(
   parameter int BANKS     = SBCSM_NUM_BANKS,
   parameter int BURST_LEN = SBCSM_BURST_LEN_DEFAULT
)(
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             clk_enable,
   input  wire logic             chip_select_n,
   input  wire logic             ras_n,
   input  wire logic             cas_n,
   input  wire logic             we_n,
   input  wire logic [1:0]       bank_addr,
   input  wire logic             auto_close_flag,
   output logic [BANKS*4-1:0]    bank_state,
   output logic                  illegal_cmd,
   output logic                  self_refresh,
   output logic                  power_down,
   output logic                  clock_suspend,
   output logic                  inputs_disabled
);
   typedef enum logic [2:0] {SBCSM_RUN, SBCSM_SELF, SBCSM_SREC, SBCSM_PDOWN,
                             SBCSM_SUSP} sbcsm_mode_t;
   sbcsm_cmd_t  cmd;
   sbcsm_mode_t mode_q, mode_d;
   logic        cke_prev_q;
   logic [2:0]  srec_cnt_q, srec_cnt_d;
   logic        illegal_q, illegal_d;
   sbcsm_bank_t st_q [BANKS];
   sbcsm_bank_t st_d [BANKS];
   logic [2:0]  cnt_q [BANKS];
   logic [2:0]  cnt_d [BANKS];
   logic [BANKS-1:0] bad;
   logic        all_idle, any_active, cmd_ok;
   logic        self_q, pdown_q, susp_q, dis_q;

   sbcsm_cmd_decode u_dec (
      .chip_select_n (chip_select_n),
      .ras_n         (ras_n),
      .cas_n         (cas_n),
      .we_n          (we_n),
      .cmd           (cmd)
   );

   // Commands count only in run mode with enable high before
   assign cmd_ok = (mode_q == SBCSM_RUN) && cke_prev_q; // R01

   always_comb begin
      all_idle   = 1'b1;
      any_active = 1'b1;
      for (int i = 0; i < BANKS; i++) begin
         if (st_q[i] != SBCSM_IDLE) all_idle = 1'b0;
         if (st_q[i] != SBCSM_IDLE && st_q[i] != SBCSM_ROW_ACTIVE) any_active = 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < BANKS; g++) begin : g_bank
         logic sel;
         assign sel = (bank_addr == 2'(g)); // R05
         always_comb begin
            st_d[g]  = st_q[g];
            cnt_d[g] = (cnt_q[g] != SBCSM_CNT_ZERO) ? cnt_q[g] - 3'h1 : cnt_q[g];
            bad[g]   = 1'b0;
            if (cmd_ok) begin
               unique case (st_q[g])
                  SBCSM_IDLE: begin
                     if (sel && cmd == SBCSM_ACT) begin
                        st_d[g] = SBCSM_ACTIVATING;
                        cnt_d[g] = 3'(SBCSM_ACTIVATE_TO_ACCESS_DELAY_CYC - 1);
                     end else if (sel && (cmd == SBCSM_READ || cmd == SBCSM_WRITE))
                        bad[g] = 1'b1;
                     // Refresh with enable low is self refresh; banks stay idle
                     else if (cmd == SBCSM_REF && all_idle && clk_enable) begin
                        st_d[g] = SBCSM_REFRESHING;
                        cnt_d[g] = 3'(SBCSM_TRC_CYC - 1);
                     end else if (cmd == SBCSM_MRS && all_idle) begin
                        st_d[g] = SBCSM_MODE_ACCESS;
                        cnt_d[g] = 3'(SBCSM_MODE_ACCESS_CLK - 1);
                     end
                  end
                  SBCSM_ACTIVATING, SBCSM_PRECHARGING, SBCSM_READ_AP, SBCSM_WRITE_AP: begin
                     if (sel && cmd inside {SBCSM_BST, SBCSM_READ, SBCSM_WRITE, SBCSM_ACT})
                        bad[g] = 1'b1; // R04
                     else if (cmd == SBCSM_REF || cmd == SBCSM_MRS)
                        bad[g] = 1'b1; // R04
                     else if (sel && cmd == SBCSM_PRE && st_q[g] != SBCSM_PRECHARGING)
                        bad[g] = 1'b1; // R04
                     if (cnt_q[g] == SBCSM_CNT_ZERO) begin
                        unique case (st_q[g])
                           SBCSM_ACTIVATING:  st_d[g] = SBCSM_ROW_ACTIVE;
                           SBCSM_PRECHARGING: st_d[g] = SBCSM_IDLE; // R06
                           SBCSM_READ_AP: begin
                              st_d[g] = SBCSM_PRECHARGING; // R02
                              cnt_d[g] = 3'(SBCSM_TRP_CYC - 1);
                           end
                           default: begin
                              st_d[g] = SBCSM_WREC_AP; // R03
                              cnt_d[g] = 3'(SBCSM_DATAIN_TO_PRE_CLK - 1);
                           end
                        endcase
                     end
                  end
                  SBCSM_ROW_ACTIVE, SBCSM_READING, SBCSM_WRITING, SBCSM_WREC: begin
                     if (sel && (cmd == SBCSM_READ || cmd == SBCSM_WRITE)) begin // R08
                        st_d[g] = (cmd == SBCSM_READ)
                                ? (auto_close_flag ? SBCSM_READ_AP : SBCSM_READING)
                                : (auto_close_flag ? SBCSM_WRITE_AP : SBCSM_WRITING);
                        cnt_d[g] = 3'(BURST_LEN - 1);
                     end else if (sel && cmd == SBCSM_PRE && st_q[g] != SBCSM_WREC) begin
                        st_d[g] = SBCSM_PRECHARGING;
                        cnt_d[g] = 3'(SBCSM_TRP_CYC - 1);
                     end else if (sel && cmd == SBCSM_BST && st_q[g] != SBCSM_WREC)
                        st_d[g] = SBCSM_ROW_ACTIVE;
                     else if (sel && (cmd == SBCSM_ACT || cmd == SBCSM_PRE))
                        bad[g] = 1'b1;
                     else if (cmd == SBCSM_REF || cmd == SBCSM_MRS)
                        bad[g] = 1'b1;
                     else if (cnt_q[g] == SBCSM_CNT_ZERO) begin
                        if (st_q[g] == SBCSM_READING || st_q[g] == SBCSM_WREC) // R07
                           st_d[g] = SBCSM_ROW_ACTIVE;
                        else if (st_q[g] == SBCSM_WRITING) begin
                           st_d[g] = SBCSM_WREC;
                           cnt_d[g] = 3'(SBCSM_DATAIN_TO_PRE_CLK - 1);
                        end
                     end
                  end
                  SBCSM_WREC_AP: begin
                     if (sel && cmd inside {SBCSM_READ, SBCSM_WRITE, SBCSM_ACT, SBCSM_PRE})
                        bad[g] = 1'b1; // R09
                     else if (cmd == SBCSM_REF || cmd == SBCSM_MRS)
                        bad[g] = 1'b1; // R09
                     if (cnt_q[g] == SBCSM_CNT_ZERO) begin
                        st_d[g] = SBCSM_PRECHARGING; // R09
                        cnt_d[g] = 3'(SBCSM_TRP_CYC - 1);
                     end
                  end
                  SBCSM_REFRESHING: begin
                     if (!(cmd inside {SBCSM_DESELECT_CMD, SBCSM_NOP, SBCSM_BST}))
                        bad[g] = 1'b1; // R10
                     if (cnt_q[g] == SBCSM_CNT_ZERO)
                        st_d[g] = SBCSM_IDLE; // R10
                  end
                  SBCSM_MODE_ACCESS: begin
                     if (!(cmd inside {SBCSM_DESELECT_CMD, SBCSM_NOP}))
                        bad[g] = 1'b1; // R21
                     if (cnt_q[g] == SBCSM_CNT_ZERO)
                        st_d[g] = SBCSM_IDLE;
                  end
               endcase
            end else if (mode_q == SBCSM_RUN || mode_q == SBCSM_SUSP) begin
               // Suspended bursts freeze their counters
               cnt_d[g] = cnt_q[g];
            end
            if (bad[g]) begin
               st_d[g]  = st_q[g];
               cnt_d[g] = (cnt_q[g] != SBCSM_CNT_ZERO) ? cnt_q[g] - 3'h1 : cnt_q[g];
            end
         end
         always_ff @(posedge core_clk) begin
            st_q[g]  <= reset ? SBCSM_IDLE : st_d[g];
            cnt_q[g] <= reset ? SBCSM_CNT_ZERO : cnt_d[g];
         end
         assign bank_state[g*4 +: 4] = st_q[g];
      end
   endgenerate

   always_comb begin
      mode_d     = mode_q;
      srec_cnt_d = (srec_cnt_q != SBCSM_CNT_ZERO) ? srec_cnt_q - 3'h1 : srec_cnt_q;
      illegal_d  = cmd_ok && (|bad);
      unique case (mode_q)
         SBCSM_RUN: begin
            if (cke_prev_q && !clk_enable) begin
               if (all_idle && cmd == SBCSM_REF)
                  mode_d = SBCSM_SELF; // R13
               else if (any_active)
                  mode_d = SBCSM_PDOWN; // R14
               else
                  mode_d = SBCSM_SUSP; // R19
            end
         end
         SBCSM_SELF: begin
            if (clk_enable) begin
               if (cmd == SBCSM_DESELECT_CMD || cmd == SBCSM_NOP) begin
                  mode_d = SBCSM_SREC; // R17
                  srec_cnt_d = 3'(SBCSM_TRC_CYC - 1);
               end else
                  illegal_d = 1'b1; // R17
            end
         end
         SBCSM_SREC: begin
            if (!clk_enable || !(cmd == SBCSM_DESELECT_CMD || cmd == SBCSM_NOP))
               illegal_d = 1'b1; // R18
            if (srec_cnt_q == SBCSM_CNT_ZERO)
               mode_d = SBCSM_RUN; // R18
         end
         SBCSM_PDOWN: begin
            if (clk_enable) mode_d = SBCSM_RUN; // R16
         end
         SBCSM_SUSP: begin
            if (clk_enable) mode_d = SBCSM_RUN; // R19
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      mode_q     <= reset ? SBCSM_RUN : mode_d;
      cke_prev_q <= reset ? 1'b1 : clk_enable;
      srec_cnt_q <= reset ? SBCSM_CNT_ZERO : srec_cnt_d;
      illegal_q  <= reset ? 1'b0 : illegal_d;
      self_q     <= reset ? 1'b0 : (mode_d == SBCSM_SELF);
      pdown_q    <= reset ? 1'b0 : (mode_d == SBCSM_PDOWN);
      susp_q     <= reset ? 1'b0 : (mode_d == SBCSM_SUSP);
      dis_q      <= reset ? 1'b0 : (mode_d == SBCSM_SELF) || (mode_d == SBCSM_PDOWN);
   end

   // Flags come straight from state flops
   assign illegal_cmd     = illegal_q;
   assign self_refresh    = self_q;
   assign power_down      = pdown_q;
   assign clock_suspend   = susp_q;
   assign inputs_disabled = dis_q;

   a_self_entry: assert property (@(posedge core_clk) disable iff (reset) // R13
      (mode_q == SBCSM_RUN && cke_prev_q && !clk_enable && all_idle && cmd == SBCSM_REF)
      |=> self_refresh) else $error("self refresh not entered");
   a_pdown_hold: assert property (@(posedge core_clk) disable iff (reset) // R16
      (power_down && !clk_enable) |=> power_down) else $error("power down dropped");
   a_pdown_exit: assert property (@(posedge core_clk) disable iff (reset) // R16
      (power_down && clk_enable) |=> !power_down) else $error("power down not left");
   a_srec_time: assert property (@(posedge core_clk) disable iff (reset) // R18
      (mode_q == SBCSM_SELF && clk_enable && cmd == SBCSM_NOP)
      |=> (mode_q == SBCSM_SREC) [*6] ##1 (mode_q == SBCSM_RUN))
      else $error("self refresh recovery length wrong");
   a_susp_exit: assert property (@(posedge core_clk) disable iff (reset) // R19
      (clock_suspend && clk_enable) |=> mode_q == SBCSM_RUN) else $error("suspend held");
   a_pre_idle: assert property (@(posedge core_clk) disable iff (reset) // R06
      (cmd_ok && st_q[0] == SBCSM_ROW_ACTIVE && bank_addr == 2'h0 && cmd == SBCSM_PRE)
      |=> st_q[0] == SBCSM_PRECHARGING ##1 st_q[0] == SBCSM_PRECHARGING
      ##1 st_q[0] == SBCSM_IDLE) else $error("precharge period wrong");
   a_ref_illegal: assert property (@(posedge core_clk) disable iff (reset) // R10
      (cmd_ok && st_q[0] == SBCSM_REFRESHING && cmd == SBCSM_ACT) |=> illegal_cmd)
      else $error("refresh command not flagged");
   a_mode_illegal: assert property (@(posedge core_clk) disable iff (reset) // R21
      (cmd_ok && st_q[0] == SBCSM_MODE_ACCESS && cmd == SBCSM_BST) |=> illegal_cmd)
      else $error("mode access command not flagged");
   a_rdap_pre: assert property (@(posedge core_clk) disable iff (reset) // R02
      (cmd_ok && st_q[0] == SBCSM_READ_AP && cnt_q[0] == SBCSM_CNT_ZERO && !bad[0])
      |=> st_q[0] == SBCSM_PRECHARGING) else $error("read autoclose no precharge");
   c_self: cover property (@(posedge core_clk) self_refresh);
   c_pdown: cover property (@(posedge core_clk) power_down);
   c_susp: cover property (@(posedge core_clk) clock_suspend);
   c_wrap: cover property (@(posedge core_clk) st_q[0] == SBCSM_WREC_AP);
endmodule

// ===== core/sbcsm_cmd_decode.sv
`timescale 1ns/10ps
module sbcsm_cmd_decode
   import sbcsm_pkg::*;
(
   input  wire logic       chip_select_n,
   input  wire logic       ras_n,
   input  wire logic       cas_n,
   input  wire logic       we_n,
   output sbcsm_cmd_t      cmd
);
   always_comb begin
      cmd = SBCSM_DESELECT_CMD;
      if (!chip_select_n) begin
         unique case ({ras_n, cas_n, we_n})
            3'h7:    cmd = SBCSM_NOP;
            3'h6:    cmd = SBCSM_BST;
            3'h5:    cmd = SBCSM_READ;
            3'h4:    cmd = SBCSM_WRITE;
            3'h3:    cmd = SBCSM_ACT;
            3'h2:    cmd = SBCSM_PRE;
            3'h1:    cmd = SBCSM_REF;
            3'h0:    cmd = SBCSM_MRS;
         endcase
      end
   end
endmodule

// ===== core/sbcsm_pkg.sv
package sbcsm_pkg;
   typedef enum logic [3:0] {
      SBCSM_DESELECT_CMD, SBCSM_NOP, SBCSM_BST, SBCSM_READ, SBCSM_WRITE,
      SBCSM_ACT, SBCSM_PRE, SBCSM_REF, SBCSM_MRS
   } sbcsm_cmd_t;
   typedef enum logic [3:0] {
      SBCSM_IDLE, SBCSM_ACTIVATING, SBCSM_ROW_ACTIVE, SBCSM_READING, SBCSM_WRITING,
      SBCSM_READ_AP, SBCSM_WRITE_AP, SBCSM_WREC, SBCSM_WREC_AP, SBCSM_PRECHARGING,
      SBCSM_REFRESHING, SBCSM_MODE_ACCESS
   } sbcsm_bank_t;
   localparam int  SBCSM_CLK_PERIOD_NS       = 10;
   localparam int  SBCSM_PRECHARGE_PERIOD_NS = 18;
   localparam int  SBCSM_ACT_TO_ACCESS_NS    = 18;
   localparam int  SBCSM_ROW_CYCLE_NS        = 60;
   localparam int  SBCSM_DATAIN_TO_PRE_CLK   = 2;
   localparam int  SBCSM_MODE_ACCESS_CLK     = 2;
   localparam int  SBCSM_BURST_LEN_DEFAULT   = 4;
   localparam int  SBCSM_TRP_CYC  = (SBCSM_PRECHARGE_PERIOD_NS + SBCSM_CLK_PERIOD_NS - 1)
                                    / SBCSM_CLK_PERIOD_NS;
   localparam int  SBCSM_ACTIVATE_TO_ACCESS_DELAY_CYC = (SBCSM_ACT_TO_ACCESS_NS + SBCSM_CLK_PERIOD_NS - 1)
                                    / SBCSM_CLK_PERIOD_NS;
   localparam int  SBCSM_TRC_CYC  = (SBCSM_ROW_CYCLE_NS + SBCSM_CLK_PERIOD_NS - 1)
                                    / SBCSM_CLK_PERIOD_NS;
   localparam int  SBCSM_NUM_BANKS = 4;
   localparam logic [2:0] SBCSM_CNT_ZERO = 3'h0;
endpackage

// ===== testbench/sbcsm_ctrl_model.sv
`timescale 1ns/10ps
module sbcsm_ctrl_model
   import sbcsm_pkg::*;
(
   input  wire logic       core_clk,
   output logic            clk_enable,
   output logic            chip_select_n,
   output logic            ras_n,
   output logic            cas_n,
   output logic            we_n,
   output logic [1:0]      bank_addr,
   output logic            auto_close_flag
);
   initial begin
      clk_enable = 1'h1;
      {chip_select_n, ras_n, cas_n, we_n} = 4'hF;
      bank_addr = 2'h0;
      auto_close_flag = 1'h0;
   end
   // One command per edge; spacing and data masking stay with the caller
   // Caller keeps suspend entry commands legal
   task automatic issue(input sbcsm_cmd_t c, input logic [1:0] b, input logic ap,
                        input logic ke);
      logic [3:0] p;
      p = (c == SBCSM_DESELECT_CMD) ? 4'hD : 4'(4'h8 - c);
      @(posedge core_clk);
      {chip_select_n, ras_n, cas_n, we_n} <= p;
      // Deselected: bank lines wander, not a held value
      bank_addr <= (c == SBCSM_DESELECT_CMD) ? ~bank_addr : b;
      auto_close_flag <= ap;
      clk_enable <= ke;
   endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/10ps
module tb;
   import sbcsm_pkg::*;
   logic          core_clk = 1'h0;
   logic          reset = 1'h1;
   logic          clk_enable, chip_select_n, ras_n, cas_n, we_n, auto_close_flag;
   logic [1:0]    bank_addr;
   logic [15:0]   bank_state;
   logic          illegal_cmd, self_refresh, power_down, clock_suspend, inputs_disabled;
   int            n_errors = 0;
   int            checked = 0;
   int            seed = 78;
   always #5 core_clk = ~core_clk;
   sbcsm_ctrl_model ctl (.core_clk(core_clk), .clk_enable(clk_enable),
      .chip_select_n(chip_select_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .bank_addr(bank_addr), .auto_close_flag(auto_close_flag));
   sbcsm_bank_fsm uut (.core_clk(core_clk), .reset(reset), .clk_enable(clk_enable),
      .chip_select_n(chip_select_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .bank_addr(bank_addr), .auto_close_flag(auto_close_flag), .bank_state(bank_state),
      .illegal_cmd(illegal_cmd), .self_refresh(self_refresh), .power_down(power_down),
      .clock_suspend(clock_suspend), .inputs_disabled(inputs_disabled));
   task automatic close_out;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk_st(input string nm, input sbcsm_bank_t e, input logic [1:0] b);
      logic [3:0] g;
      g = bank_state[b*4 +: 4];
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s bank %0d exp %0d got %0d", nm, b, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic go(input sbcsm_cmd_t c, input logic [1:0] b, input logic ap);
      ctl.issue(c, b, ap, 1'h1);
   endtask
   task automatic idle(input int n);
      repeat (n) ctl.issue(SBCSM_NOP, 2'h0, 1'h0, 1'h1);
      #1;
   endtask
   // Bounded wait; running out ends the run
   task automatic wait_st(input logic [1:0] b, input sbcsm_bank_t e, input int mx);
      int i;
      for (i = 0; i < mx && bank_state[b*4 +: 4] !== e; i++) idle(1);
      chk_st("wait", e, b);
      if (i == mx) close_out();
   endtask
   task automatic ill(input logic e);
      idle(1);
      chk_bit("illegal_cmd", e, illegal_cmd);
   endtask
   initial begin
      #1ms;
      n_errors++;
      $display("ERROR watchdog exp done got hang");
      close_out();
   end
   initial begin
      int k;
      logic [1:0] b;
      repeat (5) @(posedge core_clk);
      reset <= 1'h0;
      #1;
      for (k = 0; k < 4; k++) chk_st("reset", SBCSM_IDLE, 2'(k));
      chk_bit("illegal_cmd", 1'h0, illegal_cmd);
      $display("reset test done");
      // Each illegal command against a bank still activating
      for (k = 0; k < 14; k++) begin
         b = 2'($random(seed));
         go(SBCSM_ACT, b, 1'h0);
         go(sbcsm_cmd_t'(2 + k % 7), b, 1'($random(seed)));
         ill(1'h1);
         chk_st("refused", SBCSM_ACTIVATING, b);
         go(SBCSM_PRE, b ^ 2'h1, 1'h0);
         ill(1'h0);
         wait_st(b, SBCSM_ROW_ACTIVE, 4);
         go(SBCSM_PRE, b, 1'h0);
         go(SBCSM_PRE, b, 1'h0);
         ill(1'h0);
         chk_st("pre", SBCSM_PRECHARGING, b);
         wait_st(b, SBCSM_IDLE, 4);
      end
      $display("random illegal test done");
      go(SBCSM_ACT, 2'h0, 1'h0);
      wait_st(2'h0, SBCSM_ROW_ACTIVE, 4);
      go(SBCSM_READ, 2'h0, 1'h1);
      go(SBCSM_BST, 2'h0, 1'h0);
      ill(1'h1);
      chk_st("read ap", SBCSM_READ_AP, 2'h0);
      wait_st(2'h0, SBCSM_PRECHARGING, 8);
      wait_st(2'h0, SBCSM_IDLE, 4);
      go(SBCSM_ACT, 2'h0, 1'h0);
      wait_st(2'h0, SBCSM_ROW_ACTIVE, 4);
      go(SBCSM_WRITE, 2'h0, 1'h1);
      wait_st(2'h0, SBCSM_WREC_AP, 8);
      go(SBCSM_READ, 2'h0, 1'h0);
      ill(1'h1);
      wait_st(2'h0, SBCSM_PRECHARGING, 3);
      wait_st(2'h0, SBCSM_IDLE, 4);
      $display("autoclose test done");
      go(SBCSM_ACT, 2'h0, 1'h0);
      wait_st(2'h0, SBCSM_ROW_ACTIVE, 4);
      go(SBCSM_WRITE, 2'h0, 1'h0);
      wait_st(2'h0, SBCSM_WREC, 8);
      go(SBCSM_READ, 2'h0, 1'h0);
      ill(1'h0);
      chk_st("wrec read", SBCSM_READING, 2'h0);
      wait_st(2'h0, SBCSM_ROW_ACTIVE, 8);
      go(SBCSM_WRITE, 2'h0, 1'h0);
      wait_st(2'h0, SBCSM_WREC, 8);
      go(SBCSM_BST, 2'h0, 1'h0);
      ill(1'h0);
      wait_st(2'h0, SBCSM_ROW_ACTIVE, 3);
      $display("write recovery test done");
      // Suspend in mid-burst freezes the bank
      go(SBCSM_READ, 2'h0, 1'h0);
      repeat (3) ctl.issue(SBCSM_NOP, 2'h0, 1'h0, 1'h0);
      #1;
      chk_bit("clock_suspend", 1'h1, clock_suspend);
      chk_st("frozen", SBCSM_READING, 2'h0);
      idle(3);
      chk_bit("clock_suspend", 1'h0, clock_suspend);
      wait_st(2'h0, SBCSM_ROW_ACTIVE, 8);
      ctl.issue(SBCSM_NOP, 2'h0, 1'h0, 1'h0);
      repeat (2) ctl.issue(SBCSM_PRE, 2'h0, 1'h0, 1'h0);
      #1;
      chk_bit("power_down", 1'h1, power_down);
      chk_bit("inputs_disabled", 1'h1, inputs_disabled);
      chk_st("ignored", SBCSM_ROW_ACTIVE, 2'h0);
      idle(3);
      chk_bit("power_down", 1'h0, power_down);
      go(SBCSM_PRE, 2'h0, 1'h0);
      wait_st(2'h0, SBCSM_IDLE, 5);
      $display("power test done");
      go(SBCSM_REF, 2'h0, 1'h0);
      go(SBCSM_ACT, 2'h1, 1'h0);
      ill(1'h1);
      chk_st("refresh", SBCSM_REFRESHING, 2'h3);
      wait_st(2'h3, SBCSM_IDLE, 8);
      go(SBCSM_MRS, 2'h0, 1'h0);
      go(SBCSM_BST, 2'h0, 1'h0);
      ill(1'h1);
      chk_st("mode", SBCSM_MODE_ACCESS, 2'h2);
      wait_st(2'h2, SBCSM_IDLE, 4);
      $display("refresh and mode test done");
      ctl.issue(SBCSM_REF, 2'h0, 1'h0, 1'h0);
      repeat (3) ctl.issue(SBCSM_DESELECT_CMD, 2'h0, 1'h0, 1'h0);
      #1;
      chk_bit("self_refresh", 1'h1, self_refresh);
      chk_bit("inputs_disabled", 1'h1, inputs_disabled);
      go(SBCSM_NOP, 2'h0, 1'h0);
      go(SBCSM_READ, 2'h1, 1'h0);
      ill(1'h1);
      for (k = 0; k < 10 && self_refresh !== 1'h0; k++) idle(1);
      chk_bit("self_refresh", 1'h0, self_refresh);
      for (k = 0; k < 4; k++) chk_st("after", SBCSM_IDLE, 2'(k));
      idle(6);
      go(SBCSM_ACT, 2'h1, 1'h0);
      idle(1);
      chk_st("recovered", SBCSM_ACTIVATING, 2'h1);
      $display("self refresh test done");
      close_out();
   end
endmodule
